//--- inc/eic_pkg.sv
// constants for the encoder index capture block
package eic_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG = 8'h07;
  localparam logic [7:0] IDX_INT_POS = 8'h21;
  localparam logic [7:0] IDX_INT_CAP = 8'h36;
  localparam logic [7:0] IDX_ENCODER_POS = 8'h50;
  localparam logic [7:0] IDX_ENC_CAP = 8'h51;
  localparam logic [7:0] IDX_REVS = 8'h5e;
  localparam logic [7:0] IDX_PRESET = 8'h5f;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  // encoder_config field positions
  localparam int CFG_CONT = 0;
  localparam int CFG_ONCE = 1;
  localparam int CFG_PRESET = 2;
  localparam int CFG_CAP_ENC = 3;
  localparam int CFG_CAP_INT = 4;
  localparam int CFG_MT_EN = 5;
  localparam int CFG_MT_SIGNED = 6;
  localparam int CFG_MT_CALC = 7;
  localparam int CFG_ABS_EN = 8;
  localparam int CFG_W = 9;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
  // serial frame layout: revolution field first, then single-turn angle
  localparam int ST_BITS = 16;
  localparam int MT_BITS = 12;
  localparam int FRAME_BITS = ST_BITS + MT_BITS;
  localparam int REV_W = 32 - ST_BITS;
  // timing
  localparam int CLK_NS = 100;
  localparam int HALF_NS = 500;
  localparam int PAUSE_NS = 25000;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAUSE_CYC = (PAUSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 9;
  localparam int BIT_W = 5;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  typedef enum logic [2:0] {
    SSI_IDLE = 3'b000,
    SSI_START = 3'b001,
    SSI_BIT_HI = 3'b010,
    SSI_BIT_LO = 3'b011,
    SSI_PAUSE = 3'b100
  } eic_ssi_t;
endpackage

//--- core/eic_encoder_index_capture.sv
// encoder index capture, revolution handling and serial clock, AHB-Lite regs
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module eic_encoder_index_capture (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // qualified index event
  input wire logic indexEvent,
  // ramp position steps
  input wire logic rampStep,
  input wire logic rampDir,
  // serial encoder
  output logic encSclk,
  input wire logic encData
);

  logic [1:0] rstPipe_q;
  logic rstN;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstN = rstPipe_q[1];

  // bus slave: zero wait states, read data sampled in address phase
  logic accept;
  logic [7:0] addrIdx;
  logic addrOk;
  logic wrPend_q;
  logic [7:0] wrIdx_q;
  logic [31:0] rdMux;
  logic [31:0] hrdata_q;

  assign accept = hsel & hready & htrans[1];
  assign addrIdx = haddr[eic_pkg::IDX_MSB:eic_pkg::IDX_LSB];
  assign addrOk = (haddr[31:eic_pkg::IDX_MSB+1] == '0) &&
                  (haddr[eic_pkg::IDX_LSB-1:0] == '0);
  assign hreadyout = 1'b1;
  assign hresp = eic_pkg::HRESP_OKAY;
  assign hrdata = hrdata_q;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 8'h00;
    end else begin
      wrPend_q <= accept & hwrite & addrOk;
      wrIdx_q <= addrIdx;
    end
  end

  logic wrCfg, wrIntPos, wrEncPos, wrPreset;
  assign wrCfg = wrPend_q && (wrIdx_q == eic_pkg::IDX_CONFIG);
  assign wrIntPos = wrPend_q && (wrIdx_q == eic_pkg::IDX_INT_POS);
  assign wrEncPos = wrPend_q && (wrIdx_q == eic_pkg::IDX_ENCODER_POS);
  assign wrPreset = wrPend_q && (wrIdx_q == eic_pkg::IDX_PRESET);

  // configuration and index qualification
  logic [eic_pkg::CFG_W-1:0] cfg_q;
  logic cont, once, idxHit, presetFire, capEnc, capInt, onceClear;

  assign cont = cfg_q[eic_pkg::CFG_CONT];
  assign once = cfg_q[eic_pkg::CFG_ONCE];
  assign idxHit = indexEvent & (cont | once);
  assign presetFire = idxHit & cfg_q[eic_pkg::CFG_PRESET];
  assign capEnc = idxHit & cfg_q[eic_pkg::CFG_CAP_ENC];
  assign capInt = capEnc & cfg_q[eic_pkg::CFG_CAP_INT];
  // continuous mode leaves a pending once arm untouched
  assign onceClear = indexEvent & once & ~cont;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cfg_q <= eic_pkg::CFG_RESET;
    end else if (wrCfg) begin
      // software arming in the clearing cycle wins
      cfg_q <= hwdata[eic_pkg::CFG_W-1:0];
    end else if (onceClear) begin
      cfg_q[eic_pkg::CFG_ONCE] <= 1'b0;
    end
  end

  // internal ramp position and its capture
  logic [31:0] intPos_q, intCap_q;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      intPos_q <= 32'h0;
    end else if (wrIntPos) begin
      intPos_q <= hwdata;
    end else if (rampStep) begin
      intPos_q <= rampDir ? intPos_q - 32'h1 : intPos_q + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      intCap_q <= 32'h0;
    end else if (capInt) begin
      intCap_q <= intPos_q;
    end
  end

  // serial clock generator and receiver
  eic_pkg::eic_ssi_t ssiState_q;
  logic [eic_pkg::CNT_W-1:0] cnt_q;
  logic [eic_pkg::BIT_W-1:0] bitCnt_q;
  logic [eic_pkg::FRAME_BITS-1:0] shift_q;
  logic sclk_q, frameDone_q;

  assign encSclk = sclk_q;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ssiState_q <= eic_pkg::SSI_IDLE;
      cnt_q <= '0;
      bitCnt_q <= '0;
      sclk_q <= 1'b1;
      shift_q <= '0;
      frameDone_q <= 1'b0;
    end else begin
      frameDone_q <= 1'b0;
      case (ssiState_q)
        eic_pkg::SSI_IDLE: begin
          if (cfg_q[eic_pkg::CFG_ABS_EN]) begin
            // high to low on the clock requests a frame
            sclk_q <= 1'b0;
            cnt_q <= eic_pkg::CNT_W'(eic_pkg::HALF_CYC - 1);
            ssiState_q <= eic_pkg::SSI_START;
          end
        end
        eic_pkg::SSI_START: begin
          if (cnt_q == '0) begin
            sclk_q <= 1'b1;
            cnt_q <= eic_pkg::CNT_W'(eic_pkg::HALF_CYC - 1);
            bitCnt_q <= eic_pkg::BIT_W'(eic_pkg::FRAME_BITS - 1);
            ssiState_q <= eic_pkg::SSI_BIT_HI;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        eic_pkg::SSI_BIT_HI: begin
          if (cnt_q == '0) begin
            // sample on the falling edge
            sclk_q <= 1'b0;
            shift_q <= {shift_q[eic_pkg::FRAME_BITS-2:0], encData};
            cnt_q <= eic_pkg::CNT_W'(eic_pkg::HALF_CYC - 1);
            ssiState_q <= eic_pkg::SSI_BIT_LO;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        eic_pkg::SSI_BIT_LO: begin
          if (cnt_q == '0) begin
            sclk_q <= 1'b1;
            if (bitCnt_q == '0) begin
              frameDone_q <= 1'b1;
              cnt_q <= eic_pkg::CNT_W'(eic_pkg::PAUSE_CYC - 1);
              ssiState_q <= eic_pkg::SSI_PAUSE;
            end else begin
              bitCnt_q <= bitCnt_q - 1'b1;
              cnt_q <= eic_pkg::CNT_W'(eic_pkg::HALF_CYC - 1);
              ssiState_q <= eic_pkg::SSI_BIT_HI;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        eic_pkg::SSI_PAUSE: begin
          if (cnt_q == '0) begin
            ssiState_q <= eic_pkg::SSI_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          ssiState_q <= eic_pkg::SSI_IDLE;
        end
      endcase
    end
  end

  // revolution interpretation
  logic [eic_pkg::MT_BITS-1:0] mtRaw;
  logic [eic_pkg::ST_BITS-1:0] stRaw, angle_q, delta;
  logic [31:0] revs_q, revs_d, composite, composite_q;
  logic wrapFwd, wrapBwd;

  assign mtRaw = shift_q[eic_pkg::FRAME_BITS-1 -: eic_pkg::MT_BITS];
  assign stRaw = shift_q[eic_pkg::ST_BITS-1:0];
  assign delta = stRaw - angle_q;
  // valid only while consecutive angles differ by less than half a turn
  assign wrapFwd = ~delta[eic_pkg::ST_BITS-1] && (stRaw < angle_q);
  assign wrapBwd = delta[eic_pkg::ST_BITS-1] && (stRaw > angle_q);

  always_comb begin
    revs_d = 32'h0;
    if (cfg_q[eic_pkg::CFG_MT_EN]) begin
      if (cfg_q[eic_pkg::CFG_MT_SIGNED]) begin
        revs_d = 32'(signed'(mtRaw));
      end else begin
        revs_d = 32'(mtRaw);
      end
    end else if (cfg_q[eic_pkg::CFG_MT_CALC]) begin
      if (wrapFwd) begin
        revs_d = revs_q + 32'h1;
      end else if (wrapBwd) begin
        revs_d = revs_q - 32'h1;
      end else begin
        revs_d = revs_q;
      end
    end
  end

  assign composite = {revs_d[eic_pkg::REV_W-1:0], stRaw};

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      revs_q <= 32'h0;
      angle_q <= '0;
      composite_q <= 32'h0;
    end else if (frameDone_q) begin
      revs_q <= revs_d;
      angle_q <= stRaw;
      composite_q <= composite;
    end
  end

  // encoder position: absolute value plus an offset set by writes and presets
  logic [31:0] encPos_q, offset_q, preset_q, encCap_q;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      preset_q <= 32'h0;
    end else if (wrPreset) begin
      preset_q <= hwdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      encPos_q <= 32'h0;
      offset_q <= 32'h0;
    end else if (wrEncPos) begin
      encPos_q <= hwdata;
      offset_q <= hwdata - composite_q;
    end else if (presetFire) begin
      encPos_q <= preset_q;
      offset_q <= preset_q - composite_q;
    end else if (frameDone_q) begin
      encPos_q <= composite + offset_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      encCap_q <= 32'h0;
    end else if (capEnc) begin
      encCap_q <= encPos_q;
    end
  end

  // read decode
  always_comb begin
    rdMux = 32'h0;
    if (!addrOk) begin
      rdMux = 32'h0;
    end else if (addrIdx == eic_pkg::IDX_CONFIG) begin
      rdMux = 32'(cfg_q);
    end else if (addrIdx == eic_pkg::IDX_INT_POS) begin
      rdMux = intPos_q;
    end else if (addrIdx == eic_pkg::IDX_INT_CAP) begin
      rdMux = intCap_q;
    end else if (addrIdx == eic_pkg::IDX_ENCODER_POS) begin
      rdMux = encPos_q;
    end else if (addrIdx == eic_pkg::IDX_ENC_CAP) begin
      rdMux = encCap_q;
    end else if (addrIdx == eic_pkg::IDX_REVS) begin
      rdMux = revs_q;
    end else if (addrIdx == eic_pkg::IDX_PRESET) begin
      rdMux = preset_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      hrdata_q <= 32'h0;
    end else if (accept && !hwrite) begin
      hrdata_q <= rdMux;
    end
  end

endmodule // eic_encoder_index_capture

`default_nettype wire

//--- bench/eic_monitor.sv
// checker for bus answers, capture hold and serial clock shape
`timescale 1ns/10ps
`default_nettype none
module eic_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  // index and serial clock
  input wire logic indexEvent,
  input wire logic encSclk
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic rdReq, capRd_q, capOk_q, seen_q;
  logic [31:0] capVal_q;
  logic [8:0] hiCnt_q;
  assign rdReq = hsel && hready && htrans[1] && !hwrite;
  // a capture read stays trusted only until the next index event
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      capRd_q <= 1'b0;
      capOk_q <= 1'b0;
      capVal_q <= 32'h0;
      hiCnt_q <= 9'h0;
      seen_q <= 1'b0;
    end else begin
      capRd_q <= rdReq && haddr == 32'h144;
      capOk_q <= !indexEvent && (capOk_q || capRd_q);
      capVal_q <= capRd_q ? hrdata : capVal_q;
      hiCnt_q <= !encSclk ? 9'h0 : hiCnt_q + {8'h0, hiCnt_q != 9'h1ff};
      seen_q <= seen_q || !encSclk;
    end
  end
  AST_RESP_OKAY: assert property (hresp == eic_pkg::HRESP_OKAY)
    else $error("response not okay");
  AST_NO_WAIT: assert property (hreadyout)
    else $error("wait state inserted");
  AST_RD_HOLD: assert property (!rdReq |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (rdReq && haddr[31:10] != 22'h0
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  AST_CAP_HOLD: assert property (rdReq && haddr == 32'h144 && capOk_q &&
    !indexEvent |=> hrdata == capVal_q) else $error("capture changed");
  AST_SCLK_LOW: assert property ($fell(encSclk)
    |-> !encSclk [*5] ##1 encSclk) else $error("serial low phase wrong");
  AST_SCLK_HIGH: assert property ($rose(encSclk) |-> encSclk [*5])
    else $error("serial high phase short");
  AST_SCLK_GAP: assert property ($fell(encSclk) |-> !seen_q ||
    hiCnt_q == 9'h5 || hiCnt_q >= 9'hfa) else $error("frame pause wrong");
  cover property (rdReq && haddr == 32'h144 && capOk_q);
  cover property ($fell(encSclk) && seen_q);
  cover property (rdReq && haddr[31:10] != 22'h0);
endmodule // eic_monitor
bind eic_encoder_index_capture eic_monitor u_mon (
  .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .indexEvent(indexEvent),
  .encSclk(encSclk));
`default_nettype wire

//--- bench/eic_ssi_encoder.sv
// behavioural absolute serial encoder answering the serial clock
`timescale 1ns/10ps
`default_nettype none
module eic_ssi_encoder #(
  parameter int DLY_NS = 0
) (
  // serial link
  input wire logic encSclk,
  output logic encData,
  // position presented
  input wire logic [11:0] revsIn,
  input wire logic [15:0] angleIn
);
  logic [27:0] frameBits;
  int left;
  logic busy;
  initial begin
    encData = 1'b1;
    busy = 1'b0;
    left = 0;
  end
  // position is frozen at the start fall, as a real encoder does
  always @(negedge encSclk) begin
    if (!busy) begin
      busy = 1'b1;
      left = 28;
      frameBits = {revsIn, angleIn};
    end
  end
  always @(posedge encSclk) begin
    if (busy && left > 0) begin
      encData <= #(DLY_NS) frameBits[27];
      frameBits = frameBits << 1;
      left = left - 1;
    end else if (busy) begin
      // hold time over: the last bit is no longer shown
      busy = 1'b0;
      encData <= #(DLY_NS) !encData;
    end
  end
endmodule // eic_ssi_encoder
`default_nettype wire

//--- bench/tb.sv
// testbench: register access, index captures and serial frames
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [7:0] CFG = eic_pkg::IDX_CONFIG;
  localparam logic [7:0] IPOS = eic_pkg::IDX_INT_POS;
  localparam logic [7:0] ICAP = eic_pkg::IDX_INT_CAP;
  localparam logic [7:0] EPOS = eic_pkg::IDX_ENCODER_POS;
  localparam logic [7:0] ECAP = eic_pkg::IDX_ENC_CAP;
  logic sysClk = 1'b0, arstN = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, p0;
  logic [1:0] htrans = 2'h0, hresp;
  logic hreadyout, encSclk, encData;
  logic indexEvent = 1'b0, rampStep = 1'b0, rampDir = 1'b0;
  logic [11:0] revsIn = 12'h801;
  logic [15:0] angleIn = 16'h1234;
  logic [31:0] modes [3] = '{32'h100, 32'h120, 32'h160};
  logic [31:0] want [3] = '{32'h1234, 32'h08011234, 32'hf8011234};
  int numErrors = 0, checkCount = 0;
  always #50 sysClk = ~sysClk;
  eic_encoder_index_capture dut (.sys_clk(sysClk), .arst_n(arstN),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .indexEvent(indexEvent),
    .rampStep(rampStep), .rampDir(rampDir), .encSclk(encSclk),
    .encData(encData));
  // slow answer, still well inside the high half
  eic_ssi_encoder #(.DLY_NS(200)) u_enc (.encSclk(encSclk),
    .encData(encData), .revsIn(revsIn), .angleIn(angleIn));
  task automatic completeRun;
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge sysClk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      $display("mismatch at %0t: bus ready timeout", $time);
      numErrors++;
      completeRun;
    end
  endtask
  task automatic busXfer(input logic wr, input logic [31:0] a,
                         input logic [31:0] d);
    @(posedge sysClk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    waitRdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    waitRdy;
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    busXfer(1'b1, {22'h0, idx, 2'h0}, d);
  endtask
  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
    busXfer(1'b0, {22'h0, idx, 2'h0}, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pulse(input bit step);
    @(posedge sysClk);
    if (step) rampStep <= 1'b1;
    else indexEvent <= 1'b1;
    @(posedge sysClk);
    rampStep <= 1'b0;
    indexEvent <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge sysClk);
    arstN <= 1'b1;
    repeat (3) @(posedge sysClk);
    rdChk(CFG, 32'h0);
    wr(EPOS, 32'h1234);
    wr(eic_pkg::IDX_PRESET, 32'habcd);
    wr(IPOS, 32'h55);
    rdChk(ECAP, 32'h0);
    wr(ECAP, 32'hffff);
    rdChk(ECAP, 32'h0);
    // once, preset, both captures
    wr(CFG, 32'h1e);
    pulse(1'b0);
    rdChk(ECAP, 32'h1234);
    // unmapped read must not repeat the last read data
    busXfer(1'b0, 32'h400, 32'h0);
    chk(rd, 32'h0);
    rdChk(EPOS, 32'habcd);
    rdChk(ICAP, 32'h55);
    rdChk(CFG, 32'h1c);
    wr(EPOS, 32'h77);
    pulse(1'b0);
    rdChk(EPOS, 32'h77);
    rdChk(ECAP, 32'h1234);
    // continuous and once together, both captures
    wr(CFG, 32'h1b);
    repeat (3) pulse(1'b1);
    pulse(1'b0);
    rdChk(ICAP, 32'h58);
    rdChk(ECAP, 32'h77);
    rdChk(CFG, 32'h1b);
    wr(EPOS, 32'h99);
    rampDir <= 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    rdChk(ECAP, 32'h99);
    rdChk(ICAP, 32'h57);
    // internal capture alone is not enough
    wr(CFG, 32'h11);
    pulse(1'b1);
    pulse(1'b0);
    rdChk(ICAP, 32'h57);
    // no mode selected
    wr(CFG, 32'h18);
    wr(EPOS, 32'h42);
    pulse(1'b0);
    rdChk(ECAP, 32'h99);
    // continuous preset reloads on every index
    wr(CFG, 32'h5);
    pulse(1'b0);
    rdChk(EPOS, 32'habcd);
    wr(EPOS, 32'h42);
    pulse(1'b0);
    rdChk(EPOS, 32'habcd);
    rdChk(CFG, 32'h5);
    // two whole frames after each change of mode
    wr(EPOS, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(CFG, modes[i]);
      repeat (1150) @(posedge sysClk);
      rdChk(EPOS, want[i]);
    end
    wr(CFG, 32'h180);
    angleIn <= 16'hf000;
    repeat (1150) @(posedge sysClk);
    busXfer(1'b0, {22'h0, EPOS, 2'h0}, 32'h0);
    p0 = rd;
    angleIn <= 16'h1000;
    repeat (1150) @(posedge sysClk);
    busXfer(1'b0, {22'h0, EPOS, 2'h0}, 32'h0);
    chk(rd - p0, 32'h2000);
    completeRun;
  end
endmodule // tb
`default_nettype wire
